// ### shared/lcdcd_regs.svh
// Constants of the LCD command decoder: opcodes, field positions, resets.
// Assumes it is included by its bare name wherever a constant is needed.
`ifndef LCDCD_REGS_SVH
`define LCDCD_REGS_SVH

`define LCDCD_SLAVE_ADDR_HI 6'h1c
`define LCDCD_RW_BIT        0
`define LCDCD_CONT_BIT      7
`define LCDCD_OP_HI         6
`define LCDCD_OP_MODE       2'h2
`define LCDCD_OP_PTR        2'h0
`define LCDCD_OP_DEVSEL     4'hc
`define LCDCD_OP_BANK       5'h1e
`define LCDCD_OP_BLINK      4'he
`define LCDCD_MODE_E_BIT    3
`define LCDCD_MODE_B_BIT    2
`define LCDCD_BANK_IN_BIT   1
`define LCDCD_BANK_OUT_BIT  0
`define LCDCD_BLINK_A_BIT   2
`define LCDCD_STEP_STATIC   6'h08
`define LCDCD_STEP_MUX2     6'h04
`define LCDCD_STEP_MUX3     6'h03
`define LCDCD_STEP_MUX4     6'h02
`define LCDCD_RAM_WORDS     6'h20
`define LCDCD_BLINK_HALF1   12'h180
`define LCDCD_BLINK_HALF2   12'h300
`define LCDCD_BLINK_HALF3   12'h600
`define LCDCD_BLINK_OFF     2'h0
`define LCDCD_BLINK_F1      2'h1
`define LCDCD_BLINK_F2      2'h2
`define LCDCD_RST_PTR       5'h00
`define LCDCD_RST_SUB       3'h0

`endif

// ### shared/lcdcd_pkg.sv
// Types shared by the LCD command decoder and its display RAM.
// Assumes no other package.
package lcdcd_pkg;

  typedef enum logic [1:0] {
    LCDCD_MUX4   = 2'h0,
    LCDCD_STATIC = 2'h1,
    LCDCD_MUX2   = 2'h2,
    LCDCD_MUX3   = 2'h3
  } lcdcd_drive_t;

  typedef enum logic [4:0] {
    LCDCD_IDLE   = 5'h01,
    LCDCD_ADDR   = 5'h02,
    LCDCD_CMD    = 5'h04,
    LCDCD_DATA   = 5'h08,
    LCDCD_IGNORE = 5'h10
  } lcdcd_state_t;

endpackage

// ### shared/lcdcd_ram_if.sv
// Signals between the command decoder and the display RAM.
// Assumes both ends run on core_clk.
`timescale 1ns/1ps
interface lcdcd_ram_if;
  logic                  wr_en;
  logic [7:0]            wr_byte;
  logic [4:0]            wr_ptr;
  lcdcd_pkg::lcdcd_drive_t wr_mode;
  logic                  wr_bank;
  logic [4:0]            rd_addr;
  logic [3:0]            rd_data;

  modport ctrl (output wr_en, wr_byte, wr_ptr, wr_mode, wr_bank, rd_addr,
                input rd_data);
  modport ram  (input wr_en, wr_byte, wr_ptr, wr_mode, wr_bank, rd_addr,
                output rd_data);
endinterface

// ### core/lcdcd_ram.sv
// Display RAM of 32 words by 4 bits with the mode-dependent fill order.
// Assumes the decoder presents one data byte per wr_en pulse.
`timescale 1ns/1ps
module lcdcd_ram #(
  parameter int WORDS = 32
) (
  input  wire logic      core_clk,
  lcdcd_ram_if.ram       rif
);
  logic [3:0] mem [WORDS];
  logic [5:0] cell_addr [8];
  logic [1:0] cell_bit  [8];
  wire        is_static = (rif.wr_mode == lcdcd_pkg::LCDCD_STATIC);
  wire        is_mux2   = (rif.wr_mode == lcdcd_pkg::LCDCD_MUX2);
  wire        is_mux3   = (rif.wr_mode == lcdcd_pkg::LCDCD_MUX3);

  // The most significant data bit lands in the first cell.
  genvar j;
  generate
    for (j = 0; j < 8; j++) begin : g_cell
      localparam int K = 7 - j;
      assign cell_addr[j] = {1'b0, rif.wr_ptr} +
                            (is_static ? 6'(K) :
                             is_mux2   ? 6'(K / 2) :
                             is_mux3   ? 6'(K / 3) : 6'(K / 4));
      assign cell_bit[j]  = is_static ? {rif.wr_bank, 1'b0} :
                            is_mux2   ? {rif.wr_bank, 1'(K % 2)} :
                            is_mux3   ? 2'(K % 3) : 2'(K % 4);
    end
  endgenerate

  // Cells past the last word belong to the next cascaded device.
  always_ff @(posedge core_clk) begin
    if (rif.wr_en) begin
      for (int i = 0; i < 8; i++) begin
        if (cell_addr[i] < 6'(WORDS)) begin
          mem[cell_addr[i][4:0]][cell_bit[i]] <= rif.wr_byte[i];
        end
      end
    end
  end

  assign rif.rd_data = mem[rif.rd_addr];
endmodule

// ### core/lcdcd_top.sv
// Command decoder and display controller of a segment LCD driver.
// Assumes a byte-level receiver ahead of it that reports START, STOP and
// each received byte as one-cycle pulses on core_clk, and that sends the
// acknowledge this block asks for.
`timescale 1ns/1ps
`include "lcdcd_regs.svh"
module lcdcd_top #(
  parameter int RAM_WORDS = 32
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  input  wire logic                    bus_start,
  input  wire logic                    bus_stop,
  input  wire logic                    byte_valid,
  input  wire logic [7:0]              byte_data,
  input  wire logic                    slave_addr_lsb_strap,
  input  wire logic [2:0]              hw_subaddr,
  input  wire logic                    disp_clk_en,
  input  wire logic [4:0]              ram_rd_addr,
  output logic                         ack_reg,
  output logic                         disp_enable_reg,
  output logic                         bias_half_reg,
  output lcdcd_pkg::lcdcd_drive_t      drive_mode_reg,
  output logic [4:0]                   data_ptr_reg,
  output logic [2:0]                   subaddr_reg,
  output logic                         in_bank_reg,
  output logic                         out_bank_reg,
  output logic                         blink_alt_reg,
  output logic [1:0]                   blink_freq_sel_reg,
  output logic                         disp_visible_reg,
  output logic                         out_bank_eff_reg,
  output logic                         blink_phase_reg,
  output logic [3:0]                   ram_rd_data_reg
);

  lcdcd_ram_if rif ();

  lcdcd_ram #(
    .WORDS (RAM_WORDS)
  ) u_ram (
    .core_clk (core_clk),
    .rif      (rif)
  );

  lcdcd_pkg::lcdcd_state_t state_reg;
  lcdcd_pkg::lcdcd_state_t state_next;
  logic [11:0]             blink_cnt_reg;

  // Byte classification.
  wire st_idle   = (state_reg == lcdcd_pkg::LCDCD_IDLE);
  wire st_addr   = (state_reg == lcdcd_pkg::LCDCD_ADDR);
  wire st_cmd    = (state_reg == lcdcd_pkg::LCDCD_CMD);
  wire st_data   = (state_reg == lcdcd_pkg::LCDCD_DATA);
  wire addr_hit  = (byte_data[7:2] == `LCDCD_SLAVE_ADDR_HI) &&
                   (byte_data[1] == slave_addr_lsb_strap) &&
                   !byte_data[`LCDCD_RW_BIT];
  wire cmd_byte  = byte_valid && st_cmd && !bus_start && !bus_stop;
  wire data_byte = byte_valid && st_data && !bus_start && !bus_stop;
  wire cont_bit  = byte_data[`LCDCD_CONT_BIT];
  wire sub_match = (subaddr_reg == hw_subaddr);

  // Opcode decode; any other pattern matches nothing.
  wire op_mode   = (byte_data[`LCDCD_OP_HI -: 2] == `LCDCD_OP_MODE);
  wire op_ptr    = (byte_data[`LCDCD_OP_HI -: 2] == `LCDCD_OP_PTR);
  wire op_devsel = (byte_data[`LCDCD_OP_HI -: 4] == `LCDCD_OP_DEVSEL);
  wire op_bank   = (byte_data[`LCDCD_OP_HI -: 5] == `LCDCD_OP_BANK);
  wire op_blink  = (byte_data[`LCDCD_OP_HI -: 4] == `LCDCD_OP_BLINK);

  wire mux34     = (drive_mode_reg == lcdcd_pkg::LCDCD_MUX3) ||
                   (drive_mode_reg == lcdcd_pkg::LCDCD_MUX4);
  wire do_mode   = cmd_byte && op_mode;
  wire do_ptr    = cmd_byte && op_ptr;
  wire do_devsel = cmd_byte && op_devsel;
  wire do_bank   = cmd_byte && op_bank && !mux34;
  wire do_blink  = cmd_byte && op_blink;

  // Pointer advance per data byte; a wrap moves to the next subaddress.
  wire [5:0] ptr_step =
    (drive_mode_reg == lcdcd_pkg::LCDCD_STATIC) ? `LCDCD_STEP_STATIC :
    (drive_mode_reg == lcdcd_pkg::LCDCD_MUX2)   ? `LCDCD_STEP_MUX2 :
    (drive_mode_reg == lcdcd_pkg::LCDCD_MUX3)   ? `LCDCD_STEP_MUX3 :
                                                  `LCDCD_STEP_MUX4;
  wire [5:0] ptr_sum  = {1'b0, data_ptr_reg} + ptr_step;
  wire       ptr_wrap = (ptr_sum >= `LCDCD_RAM_WORDS);
  wire [5:0] ptr_wrapped = ptr_sum - `LCDCD_RAM_WORDS;
  wire [4:0] ptr_adv  = ptr_wrap ? ptr_wrapped[4:0] : ptr_sum[4:0];
  wire [2:0] sub_adv  = ptr_wrap ? subaddr_reg + 3'h1 : subaddr_reg;

  // Blink timing: half of each division ratio, in display clock ticks.
  wire [11:0] blink_half =
    (blink_freq_sel_reg == `LCDCD_BLINK_F1) ? `LCDCD_BLINK_HALF1 :
    (blink_freq_sel_reg == `LCDCD_BLINK_F2) ? `LCDCD_BLINK_HALF2 :
                                              `LCDCD_BLINK_HALF3;
  wire blink_on   = (blink_freq_sel_reg != `LCDCD_BLINK_OFF);
  wire blink_last = (blink_cnt_reg >= blink_half - 12'h001);
  wire alt_eff    = blink_alt_reg && !mux34;
  wire visible_next = disp_enable_reg &&
                      (!blink_on || alt_eff || !blink_phase_reg);
  wire bank_eff_next = !mux34 &&
                       (out_bank_reg ^ (blink_on && alt_eff &&
                                        blink_phase_reg));

  // Receive sequence: address byte, commands, then display data.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lcdcd_pkg::LCDCD_IDLE: begin
        state_next = lcdcd_pkg::LCDCD_IDLE;
      end
      lcdcd_pkg::LCDCD_ADDR: begin
        if (byte_valid) begin
          state_next = addr_hit ? lcdcd_pkg::LCDCD_CMD :
                                  lcdcd_pkg::LCDCD_IGNORE;
        end
      end
      lcdcd_pkg::LCDCD_CMD: begin
        if (byte_valid && !cont_bit) begin
          state_next = lcdcd_pkg::LCDCD_DATA;
        end
      end
      lcdcd_pkg::LCDCD_DATA: begin
        state_next = lcdcd_pkg::LCDCD_DATA;
      end
      lcdcd_pkg::LCDCD_IGNORE: begin
        state_next = lcdcd_pkg::LCDCD_IGNORE;
      end
      default: begin
        state_next = lcdcd_pkg::LCDCD_IDLE;
      end
    endcase
    if (bus_start) begin
      state_next = lcdcd_pkg::LCDCD_ADDR;
    end else if (bus_stop) begin
      state_next = lcdcd_pkg::LCDCD_IDLE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= lcdcd_pkg::LCDCD_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Acknowledge the address, every command, and data for this subaddress.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= byte_valid && !bus_start && !bus_stop && !st_idle &&
                 ((st_addr && addr_hit) || st_cmd ||
                  (st_data && sub_match));
    end
  end

  // Mode-set status.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      disp_enable_reg <= 1'b0;
      bias_half_reg   <= 1'b0;
      drive_mode_reg  <= lcdcd_pkg::LCDCD_MUX4;
    end else if (do_mode) begin
      disp_enable_reg <= byte_data[`LCDCD_MODE_E_BIT];
      bias_half_reg   <= byte_data[`LCDCD_MODE_B_BIT];
      drive_mode_reg  <= lcdcd_pkg::lcdcd_drive_t'(byte_data[1:0]);
    end
  end

  // Data pointer and subaddress counter.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_ptr_reg <= `LCDCD_RST_PTR;
    end else if (do_ptr) begin
      data_ptr_reg <= byte_data[4:0];
    end else if (data_byte) begin
      data_ptr_reg <= ptr_adv;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      subaddr_reg <= `LCDCD_RST_SUB;
    end else if (do_devsel) begin
      subaddr_reg <= byte_data[2:0];
    end else if (data_byte) begin
      subaddr_reg <= sub_adv;
    end
  end

  // Bank selection.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_bank_reg  <= 1'b0;
      out_bank_reg <= 1'b0;
    end else if (do_bank) begin
      in_bank_reg  <= byte_data[`LCDCD_BANK_IN_BIT];
      out_bank_reg <= byte_data[`LCDCD_BANK_OUT_BIT];
    end
  end

  // Blink selection.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      blink_alt_reg      <= 1'b0;
      blink_freq_sel_reg <= `LCDCD_BLINK_OFF;
    end else if (do_blink) begin
      blink_alt_reg      <= byte_data[`LCDCD_BLINK_A_BIT];
      blink_freq_sel_reg <= byte_data[1:0];
    end
  end

  // Blink divider runs on the display clock enable and restarts when off.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      blink_cnt_reg   <= 12'h000;
      blink_phase_reg <= 1'b0;
    end else if (!blink_on) begin
      blink_cnt_reg   <= 12'h000;
      blink_phase_reg <= 1'b0;
    end else if (disp_clk_en) begin
      blink_cnt_reg   <= blink_last ? 12'h000 : blink_cnt_reg + 12'h001;
      blink_phase_reg <= blink_phase_reg ^ blink_last;
    end
  end

  // Display-facing results of the status registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      disp_visible_reg <= 1'b0;
      out_bank_eff_reg <= 1'b0;
    end else begin
      disp_visible_reg <= visible_next;
      out_bank_eff_reg <= bank_eff_next;
    end
  end

  // RAM write path: only bytes for this device's subaddress are stored.
  assign rif.wr_en   = data_byte && sub_match && !bus_start &&
                       !bus_stop;
  assign rif.wr_byte = byte_data;
  assign rif.wr_ptr  = data_ptr_reg;
  assign rif.wr_mode = drive_mode_reg;
  assign rif.wr_bank = in_bank_reg;
  assign rif.rd_addr = ram_rd_addr;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ram_rd_data_reg <= 4'h0;
    end else begin
      ram_rd_data_reg <= rif.rd_data;
    end
  end

endmodule

// ### testbench/lcdcd_top_props.sv
// Port-level assertions for the LCD command decoder top.
// Assumes it is bound into lcdcd_top and sees only its ports.
`timescale 1ns/1ps
`include "lcdcd_regs.svh"
module lcdcd_props (
  input wire logic          core_clk,
  input wire logic          rst,
  input wire logic          bus_start,
  input wire logic          bus_stop,
  input wire logic          byte_valid,
  input wire logic [7:0]    byte_data,
  input wire logic          slave_addr_lsb_strap,
  input wire logic          ack_reg,
  input wire logic          disp_enable_reg,
  input wire logic          bias_half_reg,
  input lcdcd_pkg::lcdcd_drive_t drive_mode_reg,
  input wire logic [4:0]    data_ptr_reg,
  input wire logic [2:0]    subaddr_reg,
  input wire logic          in_bank_reg,
  input wire logic          out_bank_reg,
  input wire logic          blink_alt_reg,
  input wire logic [1:0]    blink_freq_sel_reg,
  input wire logic          disp_visible_reg,
  input wire logic          out_bank_eff_reg,
  input wire logic          blink_phase_reg
);
  logic [1:0] ph_reg;
  wire        take;
  wire        amatch;
  wire        cmd;
  wire        multi;
  assign take = byte_valid && !bus_start && !bus_stop;
  assign amatch = !byte_data[0] &&
    byte_data[7:1] == {`LCDCD_SLAVE_ADDR_HI, slave_addr_lsb_strap};
  assign cmd = take && ph_reg == 2'h2;
  assign multi = drive_mode_reg[1] == drive_mode_reg[0];
  // Follows the address, command and data phases of a transfer.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ph_reg <= 2'h0;
    end else if (bus_start) begin
      ph_reg <= 2'h1;
    end else if (bus_stop) begin
      ph_reg <= 2'h0;
    end else if (byte_valid && ph_reg == 2'h1) begin
      ph_reg <= amatch ? 2'h2 : 2'h0;
    end else if (byte_valid && ph_reg == 2'h2 && !byte_data[7]) begin
      ph_reg <= 2'h3;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_op(logic [7:0] m, logic [7:0] v);
    cmd && (byte_data & m) == v;
  endsequence
  a_addr_ack: assert property (
    take && ph_reg == 2'h1 |=> ack_reg == $past(amatch))
    else $error("address acknowledge wrong");
  a_cmd_ack: assert property (cmd |=> ack_reg)
    else $error("command not acknowledged");
  a_mode_set: assert property (
    s_op(8'h60, 8'h40) |=> {disp_enable_reg, bias_half_reg,
    drive_mode_reg} == $past(byte_data[3:0]))
    else $error("mode-set not applied");
  a_ptr_load: assert property (
    s_op(8'h60, 8'h00) |=> data_ptr_reg == $past(byte_data[4:0]))
    else $error("pointer load wrong");
  a_sub_load: assert property (
    s_op(8'h78, 8'h60) |=> subaddr_reg == $past(byte_data[2:0]))
    else $error("subaddress load wrong");
  a_bank_take: assert property (
    s_op(8'h7c, 8'h78) ##0 !multi |=>
    {in_bank_reg, out_bank_reg} == $past(byte_data[1:0]))
    else $error("bank-select not applied");
  a_bank_skip: assert property (
    s_op(8'h7c, 8'h78) ##0 multi |=> $stable({in_bank_reg, out_bank_reg}))
    else $error("bank-select applied in 3 or 4 way");
  a_blink_sel: assert property (
    s_op(8'h78, 8'h70) |=>
    {blink_alt_reg, blink_freq_sel_reg} == $past(byte_data[2:0]))
    else $error("blink-select not applied");
  a_unknown_keep: assert property (
    cmd && ((byte_data & 8'h78) == 8'h68 || (byte_data & 8'h7c) == 8'h7c)
    |=> $stable({disp_enable_reg, drive_mode_reg, data_ptr_reg,
    subaddr_reg, blink_freq_sel_reg}))
    else $error("unknown opcode changed status");
  a_mux_normal: assert property (
    multi && blink_freq_sel_reg != 2'h0 && blink_phase_reg |=>
    !disp_visible_reg)
    else $error("alternate blinking used in 3 or 4 way");
  a_multi_bank: assert property (multi ##1 multi |-> !out_bank_eff_reg)
    else $error("bank alternates in 3 or 4 way");
  a_blank_hides: assert property (!disp_enable_reg |=> !disp_visible_reg)
    else $error("blanked display visible");
  a_blink_idle: assert property (
    blink_freq_sel_reg == 2'h0 |=> !blink_phase_reg)
    else $error("blink phase runs while off");
  a_data_step: assert property (
    take && ph_reg == 2'h3 |=> data_ptr_reg != $past(data_ptr_reg))
    else $error("pointer did not advance");
endmodule

// ### testbench/lcdcd_host.sv
// Byte-level model of the bus master that writes commands and data.
// Assumes the bench calls its tasks; it only ever writes.
`timescale 1ns/1ps
module lcdcd_host (
  input  wire logic core_clk,
  input  wire logic ack_reg,
  output logic      bus_start,
  output logic      bus_stop,
  output logic      byte_valid,
  output logic [7:0] byte_data
);
  initial begin
    bus_start = 1'b0;
    bus_stop = 1'b0;
    byte_valid = 1'b0;
    byte_data = 8'h00;
  end
  task automatic frame(input logic s);
    @(posedge core_clk);
    #1;
    bus_start = s;
    bus_stop = !s;
    @(posedge core_clk);
    #1;
    bus_start = 1'b0;
    bus_stop = 1'b0;
  endtask
  // Released data shows the inverse so stale bytes cannot pass.
  task automatic put(input logic [7:0] b, output logic ak);
    @(posedge core_clk);
    #1;
    byte_valid = 1'b1;
    byte_data = b;
    @(posedge core_clk);
    #1;
    byte_valid = 1'b0;
    byte_data = ~b;
    ak = ack_reg;
  endtask
endmodule

// ### testbench/lcdcd_top_tb.sv
// Self-checking bench for the LCD command decoder top.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
`include "lcdcd_regs.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  err_total++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module lcdcd_top_tb;
  logic        core_clk, rst, bus_start, bus_stop, byte_valid, strap;
  logic        dce, ack_reg, en, bias, ib, ob, alt, vis, eff, ph, a, eib;
  logic        eob;
  logic [7:0]  byte_data, d, e;
  logic [4:0]  rd_addr, ptr, p;
  logic [3:0]  rd_data;
  logic [2:0]  hw, sub;
  logic [1:0]  fs;
  logic [16:0] snap;
  lcdcd_pkg::lcdcd_drive_t mode;
  int          err_total, n_compared, n, k, bits;
  lcdcd_top u_dut (.core_clk(core_clk), .rst(rst), .bus_start(bus_start),
    .bus_stop(bus_stop), .byte_valid(byte_valid), .byte_data(byte_data),
    .slave_addr_lsb_strap(strap), .hw_subaddr(hw), .disp_clk_en(dce),
    .ram_rd_addr(rd_addr), .ack_reg(ack_reg), .disp_enable_reg(en),
    .bias_half_reg(bias), .drive_mode_reg(mode), .data_ptr_reg(ptr),
    .subaddr_reg(sub), .in_bank_reg(ib), .out_bank_reg(ob),
    .blink_alt_reg(alt), .blink_freq_sel_reg(fs), .disp_visible_reg(vis),
    .out_bank_eff_reg(eff), .blink_phase_reg(ph), .ram_rd_data_reg(rd_data));
  lcdcd_host u_host (.core_clk(core_clk), .ack_reg(ack_reg),
    .bus_start(bus_start), .bus_stop(bus_stop), .byte_valid(byte_valid),
    .byte_data(byte_data));
  function automatic logic [7:0] adv(input logic [2:0] s0,
                                     input logic [4:0] p0,
                                     input logic [1:0] m);
    int st;
    st = (m == 2'h1) ? 8 : (m == 2'h2) ? 4 : (m == 2'h3) ? 3 : 2;
    st = st + p0;
    return (st >= 32) ? {s0 + 3'h1, 5'(st - 32)} : {s0, 5'(st)};
  endfunction
  task automatic tally_and_finish;
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic start_to(input logic l, input logic rw, output logic ak);
    u_host.frame(1'b1);
    u_host.put({`LCDCD_SLAVE_ADDR_HI, l, rw}, ak);
  endtask
  task automatic cmd(input logic [7:0] b);
    logic ak;
    u_host.put(b, ak);
    `CHK("cmd ack", 1'b1, ak)
  endtask
  task automatic wait_ph(output int c);
    logic o;
    o = ph;
    c = 0;
    while (ph === o && c < 4000) begin
      @(posedge core_clk);
      #1;
      c++;
    end
    if (c >= 4000) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    n = $urandom(32'h9bc4c0a0);
    rst = 1'b1;
    strap = 1'($urandom);
    hw = 3'($urandom);
    dce = 1'b0;
    rd_addr = 5'h00;
    err_total = 0;
    n_compared = 0;
    eib = 1'b0;
    eob = 1'b0;
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    `CHK("reset", 12'h0, {en, bias, mode, ptr, sub})
    start_to(~strap, 1'b0, a);
    `CHK("other addr", 1'b0, a)
    u_host.put(8'h49, a);
    `CHK("ignored", 2'h0, {a, en})
    start_to(strap, 1'b1, a);
    `CHK("read", 1'b0, a)
    start_to(strap, 1'b0, a);
    for (k = 0; k < 4; k++) begin
      d = {3'b110, 3'($urandom), 2'(k)};
      cmd(d);
      e = d;
      `CHK("mode", d[3:0], {en, bias, mode})
      d = {6'h3e, 2'($urandom)};
      cmd(d);
      if (k == 1 || k == 2)
        {eib, eob} = d[1:0];
      `CHK("banks", {eib, eob}, {ib, ob})
      d = {5'b11110, 1'b1, 2'(k)};
      cmd(d);
      `CHK("blink", d[2:0], {alt, fs})
      repeat (2) @(posedge core_clk);
      #1;
      if (k == 0 || k == 3)
        `CHK("eff bank", 1'b0, eff)
      else
        `CHK("eff bank", eob, eff)
      `CHK("visible", e[3], vis)
      snap = {en, bias, mode, ptr, sub, ib, ob, alt, fs};
      d = k[0] ? {6'h3f, 2'($urandom)} : {5'b11101, 3'($urandom)};
      cmd(d);
      `CHK("unknown", snap, {en, bias, mode, ptr, sub, ib, ob, alt, fs})
      d = {3'b100, 5'($urandom)};
      cmd(d);
      `CHK("ptr", d[4:0], ptr)
      d = {5'b11100, 3'($urandom)};
      cmd(d);
      `CHK("sub", d[2:0], sub)
    end
    dce = 1'b1;
    for (k = 1; k < 4; k++) begin
      cmd({5'b11110, 1'b1, 2'(k)});
      wait_ph(n);
      wait_ph(n);
      `CHK("blink half", 384 << (k - 1), n)
    end
    cmd(8'h70);
    dce = 1'b0;
    u_host.frame(1'b0);
    for (k = 0; k < 4; k++) begin
      p = k[0] ? 5'h1e : 5'($urandom);
      bits = k + 1;
      eib = 1'($urandom);
      start_to(strap, 1'b0, a);
      cmd({6'h32, 2'(k + 1)});
      cmd({6'h3e, eib, 1'b0});
      // Three-way and four-way fill uses no input bank.
      if (k > 1)
        eib = 1'b0;
      cmd({5'b11100, hw});
      u_host.put({3'b000, p}, a);
      `CHK("last cmd", 1'b1, a)
      d = 8'($urandom);
      u_host.put(d, a);
      e = adv(hw, p, 2'(k + 1));
      `CHK("data ack", 1'b1, a)
      `CHK("advance", e, {sub, ptr})
      u_host.put(~d, a);
      `CHK("sub ack", e[7:5] == hw, a)
      `CHK("advance 2", adv(e[7:5], e[4:0], 2'(k + 1)), {sub, ptr})
      u_host.frame(1'b0);
      for (n = 0; n < 8; n++) begin
        if (p + n / bits < 32) begin
          rd_addr = 5'(p + n / bits);
          repeat (2) @(posedge core_clk);
          #1;
          `CHK("ram", d[7 - n], rd_data[eib * 2 + n % bits])
        end
      end
    end
    tally_and_finish();
  end
endmodule
bind lcdcd_top lcdcd_props u_props (.*);
